// ### bench/psac_host.sv
// Purpose: Processor side model driving the SRAM bus
// Assumes: Drives only at falling edges
// Notes: Released data lines toggle
`timescale 1ns/1ps
`default_nettype none
module psac_host (
   input wire logic ref_clk,
   output var psac_pkg::psac_ctrl_s ctrl,
   output logic [psac_pkg::ADDR_W-1:0] addr,
   output logic [psac_pkg::DATA_W-1:0] dq_in,
   output logic output_enable_n,
   output logic sleep_request
);
   // All strobes high, deselected
   localparam psac_pkg::psac_ctrl_s IDLE_C = 12'hf7f;
   // Controller strobe low with first select off: deselect cycle
   localparam psac_pkg::psac_ctrl_s DESEL_C = 12'h77f;
   initial begin
      ctrl = IDLE_C;
      addr = '0;
      dq_in = '0;
      output_enable_n = 1'b1;
      sleep_request = 1'b0;
   end
   task automatic put(input psac_pkg::psac_ctrl_s c, input logic [psac_pkg::ADDR_W-1:0] a,
      input logic [psac_pkg::DATA_W-1:0] d, input logic oe_n);
      @(negedge ref_clk);
      ctrl = c;
      addr = a;
      output_enable_n = oe_n | !c.global_write_n | !c.byte_write_enable_n;
      dq_in = (c.global_write_n && c.byte_write_enable_n) ? ~dq_in : d;
   endtask : put
   task automatic sleep(input logic on);
      put(on ? DESEL_C : IDLE_C, '0, '0, 1'b1);
      sleep_request = on;
      if (!on) repeat (psac_pkg::SLEEP_RECOVERY_CYC + 4) put(IDLE_C, '0, '0, 1'b1);
   endtask : sleep
endmodule : psac_host
`default_nettype wire

// ### bench/psac_top_sva.sv
// Purpose: Port assertions for psac_top
// Assumes: One clock, async high reset
// Notes: Bound below
`timescale 1ns/1ps
`default_nettype none
module psac_checker (
   input wire logic ref_clk,
   input wire logic reset,
   input wire psac_pkg::psac_ctrl_s ctrl,
   input wire logic [psac_pkg::DATA_W-1:0] dq_out,
   input wire logic dq_oe_n,
   input wire logic output_enable_n,
   input wire logic sleep_request,
   input wire logic asleep
);
   logic sel, wr_ind, awake, wr_c, rd_c, desel;
   logic [1:0] oe_low_q;
   assign sel = !ctrl.chip_sel_first_n && ctrl.chip_sel_second && !ctrl.chip_sel_third_n;
   assign wr_ind = !ctrl.global_write_n ||
      (!ctrl.byte_write_enable_n && ctrl.byte_lane_select_n != 4'hf);
   assign awake = !asleep && !sleep_request;
   assign wr_c = awake && sel && !ctrl.controller_addr_strobe_n &&
      ctrl.processor_addr_strobe_n && wr_ind;
   assign rd_c = awake && sel && (!ctrl.processor_addr_strobe_n ||
      (!ctrl.controller_addr_strobe_n && !wr_ind));
   assign desel = awake && ((ctrl.chip_sel_first_n && !ctrl.controller_addr_strobe_n) ||
      (!ctrl.chip_sel_first_n && (!ctrl.processor_addr_strobe_n ||
      !ctrl.controller_addr_strobe_n) && (!ctrl.chip_sel_second || ctrl.chip_sel_third_n)));
   // Counts consecutive sampled cycles with output enable low
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         oe_low_q <= 2'h0;
      end else if (output_enable_n) begin
         oe_low_q <= 2'h0;
      end else if (oe_low_q != 2'h3) begin
         oe_low_q <= oe_low_q + 2'h1;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   a_reset_quiet: assert property ($fell(reset) |-> dq_oe_n && !asleep && dq_out == '0)
      else $error("outputs active at reset release");
   a_oe_high_off: assert property (output_enable_n [*3] |-> dq_oe_n)
      else $error("pins driven with output enable high");
   a_asleep_off: assert property (asleep |-> dq_oe_n)
      else $error("pins driven while asleep");
   a_sleep_entry: assert property (sleep_request [*6] |-> asleep)
      else $error("sleep not entered");
   a_sleep_exit: assert property (!sleep_request [*6] |-> !asleep)
      else $error("sleep not left");
   a_entry_not_instant: assert property ($rose(sleep_request) && !asleep |=> !asleep)
      else $error("sleep entered too early");
   a_write_pins_off: assert property (wr_c |=> dq_oe_n)
      else $error("pins driven after write");
   a_desel_pins_off: assert property (desel |=> dq_oe_n)
      else $error("pins driven after deselect");
   a_read_pins_on: assert property (rd_c ##1 rd_c ##1 (rd_c && oe_low_q == 2'h3 &&
      !output_enable_n) |=> !dq_oe_n)
      else $error("read data not driven");
endmodule : psac_checker
bind psac_top psac_checker u_chk (.ref_clk, .reset, .ctrl, .dq_out, .dq_oe_n,
   .output_enable_n, .sleep_request, .asleep);
`default_nettype wire

// ### bench/tb_top.sv
// Purpose: Self-checking bench for psac_top
// Assumes: Host model drives the bus
// Notes: Expected contents kept in mem
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int AW = psac_pkg::ADDR_W;
   localparam int LW = psac_pkg::LANE_W;
   logic ref_clk, reset, burst_order, dq_oe_n, output_enable_n, sleep_request, asleep;
   psac_pkg::psac_ctrl_s ctrl, idle_c, desel_c;
   logic [AW-1:0] addr;
   logic [psac_pkg::DATA_W-1:0] dq_in, dq_out;
   logic [psac_pkg::DATA_W-1:0] mem [int];
   int num_errors = 0;
   int comparisons = 0;
   int cnt [5] = '{0, 1, 1, 2, 3};
   psac_top dut (.ref_clk, .reset, .ctrl, .addr, .dq_in, .dq_out, .dq_oe_n,
      .output_enable_n, .sleep_request, .burst_order, .asleep);
   psac_host host (.ref_clk, .ctrl, .addr, .dq_in, .output_enable_n, .sleep_request);
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   function automatic psac_pkg::psac_ctrl_s mk(input logic sc, sp, step_n, glob_n, bytes_n,
      input logic [3:0] bl, input logic sel);
      mk = {sc, sp, step_n, !sel, sel, !sel, glob_n, bytes_n, bl};
   endfunction : mk
   task automatic chk(input logic [psac_pkg::DATA_W-1:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic upd(input int a, input logic [psac_pkg::DATA_W-1:0] d, input logic glob_n,
      bytes_n, input logic [3:0] bl);
      for (int g = 0; g < psac_pkg::LANES; g++) begin
         if (!glob_n || (!bytes_n && !bl[g])) mem[a][g*LW +: LW] = d[g*LW +: LW];
      end
   endtask : upd
   task automatic wr(input int a, input logic [psac_pkg::DATA_W-1:0] d, input logic glob_n,
      bytes_n, input logic [3:0] bl);
      host.put(mk(1'b0, 1'b1, 1'b0, glob_n, bytes_n, bl, 1'b1), AW'(a), d, 1'b1);
      upd(a, d, glob_n, bytes_n, bl);
   endtask : wr
   task automatic rd3(input int a, b);
      host.put(idle_c, '0, '0, 1'b0);
      host.put(mk(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf, 1'b1), AW'(a), '0, 1'b0);
      host.put(mk(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf, 1'b1), AW'(b), '0, 1'b0);
      host.put(mk(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf, 1'b1), AW'(a), '0, 1'b0);
      chk(dq_out, mem[a]);
      chk({35'h0, dq_oe_n}, 36'h0);
      host.put(desel_c, '0, '0, 1'b0);
      chk(dq_out, mem[b]);
      host.put(idle_c, '0, '0, 1'b0);
      chk(dq_out, mem[a]);
      chk({35'h0, dq_oe_n}, 36'h1);
   endtask : rd3
   task automatic t_write();
      wr(5, 36'h1_2345_6789, 1'b0, 1'b1, 4'hf);
      wr(6, 36'hf_edcb_a987, 1'b0, 1'b1, 4'hf);
      wr(6, 36'h0_0000_0000, 1'b1, 1'b0, 4'h5);
      rd3(5, 6);
   endtask : t_write
   task automatic t_proc();
      host.put(mk(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 4'hf, 1'b1), 6, '1, 1'b0);
      host.put(desel_c, '0, '0, 1'b0);
      host.put(mk(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'hf, 1'b1), 5, '1, 1'b1);
      chk(dq_out, mem[6]);
      host.put(mk(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 4'he, 1'b1), '0, 36'h1ff, 1'b1);
      upd(5, 36'h1ff, 1'b1, 1'b0, 4'he);
      rd3(5, 6);
   endtask : t_proc
   task automatic t_burst();
      int idx;
      for (int i = 0; i < 4; i++) wr(8 + i, 36'h9_8765_4320 + 36'(i), 1'b0, 1'b1, 4'hf);
      for (int m = 0; m < 2; m++) begin
         for (int s = 0; s < 4; s++) begin
            host.put(idle_c, '0, '0, 1'b0);
            burst_order = 1'(m);
            for (int i = 0; i < 7; i++) begin
               if (i == 0) host.put(mk(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 1'b1), AW'(8 + s),
                  '0, 1'b0);
               else if (i < 5) host.put(mk(1'b1, 1'b1, i == 2, 1'b1, 1'b1, 4'hf, 1'b1), '0,
                  '0, 1'b0);
               else host.put(idle_c, '0, '0, 1'b0);
               if (i > 1) begin
                  idx = (m == 1) ? (s ^ cnt[i-2]) : ((s + cnt[i-2]) % 4);
                  chk(dq_out, mem[8 + idx]);
               end
            end
         end
      end
   endtask : t_burst
   task automatic t_sleep();
      host.sleep(1'b1);
      repeat (8) @(negedge ref_clk);
      chk({35'h0, asleep}, 36'h1);
      host.put(mk(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 4'hf, 1'b1), 5, '1, 1'b1);
      chk({35'h0, dq_oe_n}, 36'h1);
      host.sleep(1'b0);
      chk({35'h0, asleep}, 36'h0);
      rd3(5, 6);
   endtask : t_sleep
   task automatic finish_test();
      if (num_errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test
   initial begin
      repeat (3000) @(posedge ref_clk);
      num_errors++;
      finish_test();
   end
   initial begin
      reset = 1'b1;
      burst_order = 1'b1;
      idle_c = mk(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 1'b0);
      desel_c = mk(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 1'b0);
      repeat (3) @(negedge ref_clk);
      chk({35'h0, dq_oe_n}, 36'h1);
      chk(dq_out, '0);
      reset = 1'b0;
      t_write();
      t_proc();
      t_burst();
      t_sleep();
      finish_test();
   end
endmodule : tb_top
`default_nettype wire

// ### hdl/psac_array.sv
// Purpose: Storage array with per-lane write strobes and registered read
// Assumes: One access per clock
// Notes: Contents are never cleared, so sleep keeps them
`timescale 1ns/1ps
`default_nettype none
module psac_array (
   input wire logic ref_clk,
   input wire logic [psac_pkg::ADDR_W-1:0] addr,
   input wire logic [psac_pkg::LANES-1:0] lane_we,
   input wire logic [psac_pkg::DATA_W-1:0] wdata,
   output logic [psac_pkg::DATA_W-1:0] rdata
);
   logic [psac_pkg::DATA_W-1:0] mem [psac_pkg::DEPTH];

   for (genvar g = 0; g < psac_pkg::LANES; g++) begin : g_lane
      always_ff @(posedge ref_clk) begin
         if (lane_we[g]) begin
            mem[addr][g*psac_pkg::LANE_W +: psac_pkg::LANE_W] <=
               wdata[g*psac_pkg::LANE_W +: psac_pkg::LANE_W];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      rdata <= mem[addr];
   end
endmodule : psac_array
`default_nettype wire

// ### hdl/psac_burst.sv
// Purpose: Two-bit wrapping burst counter
// Assumes: Strap sampled in the caller's clock domain
// Notes: Offset from start is counted, order mapped on output
`timescale 1ns/1ps
`default_nettype none
module psac_burst (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic load,
   input wire logic [1:0] start,
   input wire logic step,
   input wire logic interleaved,
   output logic [1:0] low_addr
);
   logic [1:0] base_q;
   logic [1:0] offs_q;
   logic [1:0] offs_eff;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         base_q <= psac_pkg::BURST_RESET;
      end else if (load) begin
         base_q <= start;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         offs_q <= psac_pkg::BURST_RESET;
      end else if (load) begin
         offs_q <= 2'h0;
      end else if (step) begin
         offs_q <= offs_q + 2'h1;
      end
   end

   // Advancing continue cycle (step high) accesses the next address
   assign offs_eff = offs_q + {1'b0, step};

   always_comb begin
      if (interleaved) begin
         low_addr = base_q ^ offs_eff;
      end else begin
         low_addr = base_q + offs_eff;
      end
   end
endmodule : psac_burst
`default_nettype wire

// ### hdl/psac_pkg.sv
// Purpose: Shared constants and carriers for the pipelined SRAM access control
// Assumes: 36-bit data in four 9-bit lanes, 19-bit word address
// Notes: Sleep timing counts derive from the 25 ns clock period
package psac_pkg;
   localparam int ADDR_W = 19;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int DATA_W = LANES * LANE_W;
   localparam int DEPTH = 1 << ADDR_W;
   localparam int CLK_PERIOD_NS = 25;
   // Sleep entry and recovery: two clock periods each
   localparam int SLEEP_CYCLES = 2;
   localparam int SLEEP_RECOVERY_TIME_NS = SLEEP_CYCLES * CLK_PERIOD_NS;
   localparam int SLEEP_RECOVERY_CYC =
      (SLEEP_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] BURST_RESET = 2'h0;
   localparam logic [1:0] SLEEP_CNT_RESET = 2'h0;

   typedef enum logic [1:0] {
      PSAC_IDLE = 2'b00,
      PSAC_READ = 2'b01,
      PSAC_WRITE = 2'b11,
      PSAC_PWRITE = 2'b10
   } psac_cycle_e;

   typedef struct packed {
      logic controller_addr_strobe_n;
      logic processor_addr_strobe_n;
      logic burst_advance_n;
      logic chip_sel_first_n;
      logic chip_sel_second;
      logic chip_sel_third_n;
      logic global_write_n;
      logic byte_write_enable_n;
      logic [LANES-1:0] byte_lane_select_n;
   } psac_ctrl_s;
endpackage : psac_pkg

// ### hdl/psac_top.sv
// Purpose: Synchronous access control of a pipelined burst SRAM
// Assumes: Strobes, selects and data are synchronous to ref_clk
// Notes: Output enable and sleep are asynchronous and synchronised here
`timescale 1ns/1ps
`default_nettype none
module psac_top (
   input wire logic ref_clk,
   input wire logic reset,
   input wire psac_pkg::psac_ctrl_s ctrl,
   input wire logic [psac_pkg::ADDR_W-1:0] addr,
   input wire logic [psac_pkg::DATA_W-1:0] dq_in,
   output logic [psac_pkg::DATA_W-1:0] dq_out,
   output logic dq_oe_n,
   input wire logic output_enable_n,
   input wire logic sleep_request,
   input wire logic burst_order,
   output logic asleep
);
   psac_pkg::psac_cycle_e cyc_q;
   psac_pkg::psac_cycle_e cyc_d;
   logic [psac_pkg::ADDR_W-1:0] addr_q;
   logic [psac_pkg::ADDR_W-1:0] mem_addr;
   logic [1:0] low_addr;
   logic [psac_pkg::DATA_W-1:0] rdata;
   logic [psac_pkg::LANES-1:0] lane_we;
   logic selected;
   logic deselect;
   logic write_ind;
   logic ctl_write;
   logic cont;
   logic ext_load;
   logic step;
   logic interleaved_q;
   logic oe_s1_q;
   logic oe_s2_q;
   logic sleep_s1_q;
   logic sleep_s2_q;
   logic [1:0] sleep_cnt_q;
   logic asleep_q;
   logic active;
   logic valid_q;
   logic fresh_q;
   logic wr_now;

   // Synchronisers for asynchronous pins
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         oe_s1_q <= 1'b1;
         oe_s2_q <= 1'b1;
      end else begin
         oe_s1_q <= output_enable_n;
         oe_s2_q <= oe_s1_q;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sleep_s1_q <= 1'b0;
         sleep_s2_q <= 1'b0;
      end else begin
         sleep_s1_q <= sleep_request;
         sleep_s2_q <= sleep_s1_q;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sleep_cnt_q <= psac_pkg::SLEEP_CNT_RESET;
         asleep_q <= 1'b0;
      end else if (sleep_s2_q == asleep_q) begin
         sleep_cnt_q <= psac_pkg::SLEEP_CNT_RESET;
      end else if (sleep_cnt_q == 2'(psac_pkg::SLEEP_RECOVERY_CYC - 1)) begin
         sleep_cnt_q <= psac_pkg::SLEEP_CNT_RESET;
         asleep_q <= sleep_s2_q;
      end else begin
         sleep_cnt_q <= sleep_cnt_q + 2'h1;
      end
   end

   assign asleep = asleep_q;

   assign active = !asleep_q && !sleep_s2_q;

   // Strap registered on every clock after reset release
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         interleaved_q <= 1'b1;
      end else begin
         interleaved_q <= burst_order;
      end
   end

   assign write_ind = !ctrl.global_write_n ||
      (!ctrl.byte_write_enable_n && !(&ctrl.byte_lane_select_n));

   assign selected = !ctrl.chip_sel_first_n && ctrl.chip_sel_second &&
      !ctrl.chip_sel_third_n;

   assign deselect = (ctrl.chip_sel_first_n && !ctrl.controller_addr_strobe_n) ||
      ((!ctrl.processor_addr_strobe_n && !ctrl.chip_sel_first_n) ||
       !ctrl.controller_addr_strobe_n) &&
      (!ctrl.chip_sel_second || ctrl.chip_sel_third_n);

   assign ctl_write = selected && !ctrl.controller_addr_strobe_n &&
      ctrl.processor_addr_strobe_n && write_ind;

   assign ext_load = selected && (!ctrl.processor_addr_strobe_n ||
      !ctrl.controller_addr_strobe_n);

   assign cont = ctrl.controller_addr_strobe_n &&
      (ctrl.processor_addr_strobe_n || ctrl.chip_sel_first_n);

   assign step = active && cont && !ext_load && !ctrl.burst_advance_n &&
      cyc_q != psac_pkg::PSAC_IDLE && cyc_q != psac_pkg::PSAC_PWRITE;

   // Cycle decode
   always_comb begin
      cyc_d = cyc_q;
      if (!active) begin
         cyc_d = psac_pkg::PSAC_IDLE;
      end else if (deselect) begin
         cyc_d = psac_pkg::PSAC_IDLE;
      end else if (ext_load) begin
         if (!ctrl.processor_addr_strobe_n) begin
            cyc_d = psac_pkg::PSAC_READ;
         end else if (ctl_write) begin
            cyc_d = psac_pkg::PSAC_WRITE;
         end else begin
            cyc_d = psac_pkg::PSAC_READ;
         end
      end else if (cont && cyc_q != psac_pkg::PSAC_IDLE) begin
         cyc_d = write_ind ? psac_pkg::PSAC_WRITE : psac_pkg::PSAC_READ;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cyc_q <= psac_pkg::PSAC_IDLE;
      end else begin
         cyc_q <= cyc_d;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         addr_q <= '0;
      end else if (active && ext_load && !deselect) begin
         addr_q <= addr;
      end
   end

   psac_burst u_burst (
      .ref_clk(ref_clk),
      .reset(reset),
      .load(active && ext_load && !deselect),
      .start(addr[1:0]),
      .step(step),
      .interleaved(interleaved_q),
      .low_addr(low_addr)
   );

   assign wr_now = active && write_ind && !deselect && (ctl_write ||
      (cont && !ext_load && cyc_q != psac_pkg::PSAC_IDLE));

   always_comb begin
      if (ctl_write) begin
         mem_addr = addr;
      end else begin
         mem_addr = {addr_q[psac_pkg::ADDR_W-1:2], low_addr};
      end
   end

   always_comb begin
      lane_we = '0;
      if (wr_now) begin
         lane_we = ctrl.global_write_n ?
            (ctrl.byte_write_enable_n ? '0 : ~ctrl.byte_lane_select_n) : '1;
      end
   end

   psac_array u_array (
      .ref_clk(ref_clk),
      .addr(ext_load ? addr : mem_addr),
      .lane_we(lane_we),
      .wdata(dq_in),
      .rdata(rdata)
   );

   // Read output register and first-cycle blanking
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         dq_out <= '0;
         valid_q <= 1'b0;
         fresh_q <= 1'b0;
      end else begin
         dq_out <= rdata;
         valid_q <= active && !deselect && !wr_now &&
            (cyc_d == psac_pkg::PSAC_READ);
         fresh_q <= cyc_q == psac_pkg::PSAC_IDLE;
      end
   end

   assign dq_oe_n = !(valid_q && !fresh_q && !oe_s2_q && !wr_now &&
      active && cyc_q != psac_pkg::PSAC_IDLE);
endmodule : psac_top
`default_nettype wire
